// ==== rtl/twdm_regs.sv ====
// Functional notes
// R1: received byte readable in low eight bits
// R2: wake match register locked while protection on
// R3: three extra addresses, each with own enable
// R4: optional first data byte must also match
// R5: transmit byte written in low eight bits
// R6: transmit fifo count readable, zero when empty
// R7: receive fifo unread count readable
// R8: enable protection only with correct key
// R9: disable protection only with correct key
// R10: wrong key discards enable; key reads zero
// R11: violation flag sticky until status read
// R12: status read clears violation flag
// R13: violation source holds offending register offset
// R14: reserved bits read zero, ignore writes
//
// Implementation choice: strobed register access.
module twdm_regs (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire twdm_pkg::twdm_bus_type BUS,
    output logic [31:0] RDATA,
    output logic IRQ,
    input wire twdm_pkg::twdm_byte_type RX_IN,
    input wire logic TX_POP,
    output twdm_pkg::twdm_byte_type TX_OUT,
    input wire twdm_pkg::twdm_wake_in_type WAKE_IN,
    output logic WAKE_MATCH
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [twdm_pkg::TWDM_DEPTH-1:0][7:0] tx_mem;
        logic [twdm_pkg::TWDM_DEPTH-1:0][7:0] rx_mem;
        logic [twdm_pkg::TWDM_PTR_W-1:0] tx_wr;
        logic [twdm_pkg::TWDM_PTR_W-1:0] tx_rd;
        logic [twdm_pkg::TWDM_PTR_W-1:0] rx_wr;
        logic [twdm_pkg::TWDM_PTR_W-1:0] rx_rd;
        logic [twdm_pkg::TWDM_CNT_W-1:0] tx_cnt;
        logic [twdm_pkg::TWDM_CNT_W-1:0] rx_cnt;
        logic [7:0] tx_head;
        logic tx_avail;
        logic [31:0] wake_cfg;
        logic [3:0] wake_en;
        logic protect_on;
        logic protect_violation_flag;
        logic [23:0] protect_violation_offset;
        logic [3:0] irq_status;
        logic [3:0] irq_mask;
        logic irq;
        logic [31:0] rdata;
        twdm_pkg::twdm_wake_type wake;
        logic wake_match;
    } twdm_state_type;

    twdm_state_type state_q;
    twdm_state_type state_d;

    logic [2:0] extra_hit;
    logic any_hit;
    logic wr_acc;
    logic rd_acc;
    logic viol;
    logic tx_push;
    logic tx_pop;
    logic rx_push;
    logic rx_pop;
    logic tx_ovf;
    logic rx_ovf;
    logic wake_evt;
    logic [3:0] evt;
    logic [23:0] wr_key;

    // ----------------------------------------------------------------
    // address matching
    // ----------------------------------------------------------------

    // one comparator per extra address; unused slots never match
    function automatic logic twdm_addr_hit(
        input logic [6:0] seen,
        input logic [6:0] field,
        input logic enable
    );
        twdm_addr_hit = enable && (seen == field);
    endfunction : twdm_addr_hit

    // three extra slave addresses share one comparator shape
    for (genvar g = 0; g < 3; g++) begin : g_extra
        assign extra_hit[g] = twdm_addr_hit(WAKE_IN.addr,
            state_q.wake_cfg[g*twdm_pkg::TWDM_SADR_STEP +: 7],
            state_q.wake_en[g]); // R3
    end
    assign any_hit = |extra_hit;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------

    // register port, fifos, protection and wake matching in one pass
    always_comb begin
        state_d = state_q;
        state_d.wake_match = 1'b0;
        wr_acc = BUS.wr;
        rd_acc = BUS.rd;
        wr_key = BUS.wdata[twdm_pkg::TWDM_KEY_LSB +: 24];
        viol = 1'b0;
        tx_push = 1'b0;
        tx_ovf = 1'b0;
        rx_pop = 1'b0;
        wake_evt = 1'b0;

        // writes; protected targets are refused while protection is on
        if (wr_acc) begin
            case (BUS.addr)
                twdm_pkg::TWDM_A_PROT_MODE: begin
                    if (wr_key == twdm_pkg::TWDM_UNLOCK_PASSWORD) begin
                        state_d.protect_on = BUS.wdata[0]; // R8 R9
                    end // otherwise the enable keeps its value R10
                end
                twdm_pkg::TWDM_A_WAKE_CFG: begin
                    if (state_q.protect_on) begin
                        viol = 1'b1; // R2
                    end else begin
                        state_d.wake_cfg = BUS.wdata & twdm_pkg::TWDM_WAKE_CFG_MASK; // R14
                    end
                end
                twdm_pkg::TWDM_A_WAKE_EN: begin
                    if (state_q.protect_on) begin
                        viol = 1'b1;
                    end else begin
                        state_d.wake_en = BUS.wdata[3:0];
                    end
                end
                twdm_pkg::TWDM_A_TX_HOLD: begin
                    // a full fifo drops the byte rather than overwrite queued data
                    if (state_q.tx_cnt == twdm_pkg::TWDM_FULL) begin
                        tx_ovf = 1'b1;
                    end else begin
                        tx_push = 1'b1; // R5
                    end
                end
                twdm_pkg::TWDM_A_IRQ_STAT: begin
                    state_d.irq_status = state_q.irq_status & ~BUS.wdata[3:0];
                end
                twdm_pkg::TWDM_A_IRQ_MASK: begin
                    state_d.irq_mask = BUS.wdata[3:0];
                end
                default: begin
                end
            endcase
        end

        // reads; data stands in the following cycle only
        state_d.rdata = twdm_pkg::TWDM_ZERO;
        if (rd_acc) begin
            case (BUS.addr)
                twdm_pkg::TWDM_A_RX_HOLD: begin
                    state_d.rdata[7:0] = state_q.rx_mem[state_q.rx_rd]; // R1
                    rx_pop = state_q.rx_cnt != '0;
                end
                twdm_pkg::TWDM_A_WAKE_CFG: begin
                    state_d.rdata = state_q.wake_cfg;
                end
                twdm_pkg::TWDM_A_WAKE_EN: begin
                    state_d.rdata[3:0] = state_q.wake_en;
                end
                twdm_pkg::TWDM_A_FILL: begin
                    state_d.rdata[twdm_pkg::TWDM_CNT_W-1:0] = state_q.tx_cnt; // R6
                    state_d.rdata[twdm_pkg::TWDM_RX_FIFO_COUNT_LSB +: twdm_pkg::TWDM_CNT_W] =
                        state_q.rx_cnt; // R7
                end
                twdm_pkg::TWDM_A_PROT_MODE: begin
                    state_d.rdata[0] = state_q.protect_on; // key field reads zero R10
                end
                twdm_pkg::TWDM_A_PROT_STAT: begin
                    state_d.rdata[0] = state_q.protect_violation_flag;
                    state_d.rdata[twdm_pkg::TWDM_SRC_LSB +: 24] =
                        state_q.protect_violation_offset; // R13
                    state_d.protect_violation_flag = 1'b0; // R12
                end
                twdm_pkg::TWDM_A_IRQ_STAT: begin
                    state_d.rdata[3:0] = state_q.irq_status;
                end
                twdm_pkg::TWDM_A_IRQ_MASK: begin
                    state_d.rdata[3:0] = state_q.irq_mask;
                end
                default: begin
                end
            endcase
        end

        // a violation in the reading cycle survives the read
        if (viol) begin
            state_d.protect_violation_flag = 1'b1; // R11
            state_d.protect_violation_offset = 24'(BUS.addr - twdm_pkg::TWDM_BASE); // R13
        end

        // transmit fifo: written by software, drained by the shifter
        tx_pop = TX_POP && state_q.tx_avail;
        if (tx_push) begin
            state_d.tx_mem[state_q.tx_wr] = BUS.wdata[7:0];
            state_d.tx_wr = state_q.tx_wr + 1'b1;
        end
        if (tx_pop) begin
            state_d.tx_rd = state_q.tx_rd + 1'b1;
        end
        state_d.tx_cnt = state_q.tx_cnt + {3'h0, tx_push} - {3'h0, tx_pop}; // R6

        // receive fifo: filled by the shifter, drained by reads
        rx_push = RX_IN.valid && (state_q.rx_cnt != twdm_pkg::TWDM_FULL);
        rx_ovf = RX_IN.valid && !rx_push;
        if (rx_push) begin
            state_d.rx_mem[state_q.rx_wr] = RX_IN.data;
            state_d.rx_wr = state_q.rx_wr + 1'b1;
        end
        if (rx_pop) begin
            state_d.rx_rd = state_q.rx_rd + 1'b1;
        end
        state_d.rx_cnt = state_q.rx_cnt + {3'h0, rx_push} - {3'h0, rx_pop}; // R7

        // registered head so the shifter sees a flop, not a mux
        state_d.tx_head = state_d.tx_mem[state_d.tx_rd];
        state_d.tx_avail = state_d.tx_cnt != '0;

        // wake matching; a new address always restarts the sequence
        case (state_q.wake)
            twdm_pkg::TWDM_WAKE_IDLE: begin
                if (WAKE_IN.addr_valid && any_hit) begin
                    if (state_q.wake_en[twdm_pkg::TWDM_EN_FIRST_BYTE_MATCH_VALUE]) begin
                        state_d.wake = twdm_pkg::TWDM_WAKE_DATA; // R4
                    end else begin
                        wake_evt = 1'b1; // R3
                    end
                end
            end
            twdm_pkg::TWDM_WAKE_DATA: begin
                if (WAKE_IN.addr_valid) begin
                    state_d.wake = any_hit ? twdm_pkg::TWDM_WAKE_DATA
                                           : twdm_pkg::TWDM_WAKE_IDLE;
                end else if (WAKE_IN.data_valid) begin
                    state_d.wake = twdm_pkg::TWDM_WAKE_IDLE;
                    wake_evt = WAKE_IN.data ==
                        state_q.wake_cfg[twdm_pkg::TWDM_FIRST_BYTE_MATCH_VALUE_LSB +: 8]; // R4
                end
            end
            default: begin
                state_d.wake = twdm_pkg::TWDM_WAKE_IDLE;
            end
        endcase
        state_d.wake_match = wake_evt;

        // sticky events; setting wins over a same-cycle clear
        evt = '0;
        evt[twdm_pkg::TWDM_IRQ_VIOL] = viol;
        evt[twdm_pkg::TWDM_IRQ_TX_OVF] = tx_ovf;
        evt[twdm_pkg::TWDM_IRQ_RX_OVF] = rx_ovf;
        evt[twdm_pkg::TWDM_IRQ_WAKE] = wake_evt;
        state_d.irq_status = state_d.irq_status | evt;
        state_d.irq = |(state_d.irq_status & state_d.irq_mask);
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------

    // synchronous reset clears all control state
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // outputs come straight from the state flops
    assign RDATA = state_q.rdata;
    assign IRQ = state_q.irq;
    assign TX_OUT.valid = state_q.tx_avail;
    assign TX_OUT.data = state_q.tx_head;
    assign WAKE_MATCH = state_q.wake_match;

endmodule : twdm_regs

// ==== rtl/twdm_pkg.sv ====
package twdm_pkg;

    // ----------------------------------------------------------------
    // fifo geometry
    // ----------------------------------------------------------------
    localparam int unsigned TWDM_DEPTH = 8;
    localparam int unsigned TWDM_PTR_W = 3;
    localparam int unsigned TWDM_CNT_W = 4;
    localparam logic [TWDM_CNT_W-1:0] TWDM_FULL = 4'h8;

    // ----------------------------------------------------------------
    // register addresses (byte addresses on the register port)
    // ----------------------------------------------------------------
    localparam logic [31:0] TWDM_BASE = 32'h4001_8000;
    localparam logic [31:0] TWDM_A_RX_HOLD = 32'h4001_8030;
    localparam logic [31:0] TWDM_A_TX_HOLD = 32'h4001_8034;
    localparam logic [31:0] TWDM_A_WAKE_CFG = 32'h4001_804C;
    localparam logic [31:0] TWDM_A_FILL = 32'h4001_8050;
    localparam logic [31:0] TWDM_A_IRQ_STAT = 32'h4001_8054;
    localparam logic [31:0] TWDM_A_IRQ_MASK = 32'h4001_8058;
    localparam logic [31:0] TWDM_A_WAKE_EN = 32'h4001_805C;
    localparam logic [31:0] TWDM_A_PROT_MODE = 32'h4001_80E4;
    localparam logic [31:0] TWDM_A_PROT_STAT = 32'h4001_80E8;

    // ----------------------------------------------------------------
    // field layouts and constants
    // ----------------------------------------------------------------
    localparam logic [23:0] TWDM_UNLOCK_PASSWORD = 24'h54_5749;
    localparam int unsigned TWDM_KEY_LSB = 8;
    localparam int unsigned TWDM_SRC_LSB = 8;
    localparam int unsigned TWDM_RX_FIFO_COUNT_LSB = 16;
    localparam int unsigned TWDM_FIRST_BYTE_MATCH_VALUE_LSB = 24;
    localparam int unsigned TWDM_SADR_STEP = 8;
    localparam logic [31:0] TWDM_WAKE_CFG_MASK = 32'hFF7F_7F7F;
    localparam logic [31:0] TWDM_ZERO = 32'h0000_0000;
    // wake enable register bits
    localparam int unsigned TWDM_EN_FIRST_BYTE_MATCH_VALUE = 3;
    // interrupt status / mask bits
    localparam int unsigned TWDM_IRQ_VIOL = 0;
    localparam int unsigned TWDM_IRQ_TX_OVF = 1;
    localparam int unsigned TWDM_IRQ_RX_OVF = 2;
    localparam int unsigned TWDM_IRQ_WAKE = 3;

    // ----------------------------------------------------------------
    // carriers and state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } twdm_bus_type;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } twdm_byte_type;

    typedef struct packed {
        logic addr_valid;
        logic [6:0] addr;
        logic data_valid;
        logic [7:0] data;
    } twdm_wake_in_type;

    typedef enum logic {
        TWDM_WAKE_IDLE,
        TWDM_WAKE_DATA
    } twdm_wake_type;

endpackage : twdm_pkg

// ==== bench/twdm_regs_properties.sv ====
module twdm_regs_checker (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire twdm_pkg::twdm_bus_type BUS,
    input wire logic [31:0] RDATA,
    input wire logic IRQ,
    input wire twdm_pkg::twdm_byte_type RX_IN,
    input wire logic TX_POP,
    input wire twdm_pkg::twdm_byte_type TX_OUT,
    input wire twdm_pkg::twdm_wake_in_type WAKE_IN,
    input wire logic WAKE_MATCH
);
    timeunit 1ns;
    timeprecision 100ps;
    logic rd_q;
    logic [31:0] ra_q;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    // remember the last read so the answer cycle can be tied to its address
    always_ff @(posedge CLK) begin
        rd_q <= BUS.rd;
        ra_q <= BUS.addr - twdm_pkg::TWDM_BASE;
    end

    // ----------------------------------------------------------------
    // register port answers
    // ----------------------------------------------------------------
    a_rdata_idle: assert property (
        !BUS.rd |=> ~|RDATA) else $error("read data not zero outside answer");
    a_rx_upper_zero: assert property (
        rd_q && ra_q == 32'h0000_0030 |-> ~|RDATA[31:8]) else $error("rx upper bits");
    a_key_reads_zero: assert property (
        rd_q && ra_q == 32'h0000_00E4 |-> ~|RDATA[31:1]) else $error("key not zero");
    a_cfg_gaps_zero: assert property (
        rd_q && ra_q == 32'h0000_004C |-> ~|(RDATA & 32'h0080_8080))
        else $error("wake config reserved bits");
    a_fill_gaps_zero: assert property (
        rd_q && ra_q == 32'h0000_0050 |-> ~|{RDATA[31:20], RDATA[15:4]})
        else $error("fill reserved bits");
    a_fill_tx_empty: assert property (
        rd_q && ra_q == 32'h0000_0050 |-> (|RDATA[3:0]) == $past(TX_OUT.valid))
        else $error("tx count disagrees with head valid");
    a_stat_read_clears: assert property (
        rd_q && ra_q == 32'h0000_00E8 && BUS.rd
        && BUS.addr == twdm_pkg::TWDM_A_PROT_STAT |=> !RDATA[0])
        else $error("violation flag survived read");

    // ----------------------------------------------------------------
    // transmit head and wake pulse
    // ----------------------------------------------------------------
    a_tx_push_head: assert property (
        BUS.wr && BUS.addr == twdm_pkg::TWDM_A_TX_HOLD && !TX_OUT.valid
        |=> TX_OUT.valid && TX_OUT.data == $past(BUS.wdata[7:0]))
        else $error("pushed byte not at head");
    a_tx_head_holds: assert property (
        TX_OUT.valid && !TX_POP |=> TX_OUT.valid && $stable(TX_OUT.data))
        else $error("tx head moved without pop");
    a_wake_has_cause: assert property (
        WAKE_MATCH |-> $past(WAKE_IN.addr_valid) || $past(WAKE_IN.data_valid))
        else $error("wake match without bus event");
endmodule : twdm_regs_checker

bind twdm_regs twdm_regs_checker chk_u (.CLK, .RESET_N, .BUS, .RDATA, .IRQ, .RX_IN,
    .TX_POP, .TX_OUT, .WAKE_IN, .WAKE_MATCH);

// ==== bench/twdm_shifter_model.sv ====
module twdm_shifter_model (
    input wire logic CLK,
    output twdm_pkg::twdm_byte_type RX_IN,
    output logic TX_POP,
    output twdm_pkg::twdm_wake_in_type WAKE_IN
);
    timeunit 1ns;
    timeprecision 100ps;

    // idle at time zero, before any frame
    initial begin
        RX_IN = '0;
        TX_POP = 1'b0;
        WAKE_IN = '0;
    end

    // one received byte; the data lines are inverted afterwards so stale bytes never pass
    task automatic rx(input logic [7:0] d);
        RX_IN <= '{1'b1, d};
        @(posedge CLK);
        RX_IN <= '{1'b0, ~d};
        #1;
    endtask : rx

    // take the head byte of the transmit queue
    task automatic pop;
        TX_POP <= 1'b1;
        @(posedge CLK);
        TX_POP <= 1'b0;
        #1;
    endtask : pop

    // address then, when dv is set, the first data byte; one idle cycle closes it
    task automatic wake(input logic [6:0] a, input logic dv, input logic [7:0] d);
        WAKE_IN <= '{1'b1, a, 1'b0, ~d};
        @(posedge CLK);
        WAKE_IN <= '{1'b0, ~a, dv, d};
        @(posedge CLK);
        WAKE_IN <= '{1'b0, ~a, 1'b0, ~d};
        @(posedge CLK);
        #1;
    endtask : wake
endmodule : twdm_shifter_model

// ==== bench/twdm_regs_tb_top.sv ====
module twdm_regs_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk;
    logic reset_n;
    twdm_pkg::twdm_bus_type bus;
    logic [31:0] rdata;
    logic irq;
    logic tx_pop;
    logic wake_match;
    twdm_pkg::twdm_byte_type rx_in;
    twdm_pkg::twdm_byte_type tx_out;
    twdm_pkg::twdm_wake_in_type wake_in;
    int err_count = 0;
    int n_tests = 0;
    int n_wake = 0;
    int cycles = 0;

    twdm_regs dut_u (.CLK(clk), .RESET_N(reset_n), .BUS(bus), .RDATA(rdata), .IRQ(irq),
        .RX_IN(rx_in), .TX_POP(tx_pop), .TX_OUT(tx_out), .WAKE_IN(wake_in),
        .WAKE_MATCH(wake_match));
    twdm_shifter_model far_u (.CLK(clk), .RX_IN(rx_in), .TX_POP(tx_pop), .WAKE_IN(wake_in));

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // wake pulses are counted; the hang guard is far above the hundred or so cycles needed
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (wake_match === 1'b1) n_wake <= n_wake + 1;
        if (cycles == 3000) begin
            err_count++;
            print_verdict();
        end
    end

    // ----------------------------------------------------------------
    // bus cycles and comparison
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("Error %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    // offsets are from the block base; the strobe drops at the edge that takes it
    task automatic wr(input logic [7:0] o, input logic [31:0] d);
        bus <= '{twdm_pkg::TWDM_BASE + 32'(o), d, 1'b1, 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rdc(input logic [7:0] o, input logic [31:0] e);
        bus <= '{twdm_pkg::TWDM_BASE + 32'(o), 32'h0000_0000, 1'b0, 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1;
        chk(rdata, e);
    endtask : rdc

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_regs;
        rdc(8'h50, 32'h0000_0000);
        rdc(8'hE8, 32'h0000_0000);
        rdc(8'h00, 32'h0000_0000);
        wr(8'h4C, 32'hFFFF_FFFF);
        rdc(8'h4C, 32'hFF7F_7F7F);
        wr(8'hE4, {24'h54_5748, 8'h01});
        rdc(8'hE4, 32'h0000_0000);
        wr(8'h4C, 32'h0000_0011);
        rdc(8'h4C, 32'h0000_0011);
    endtask : t_regs

    task automatic t_protect;
        wr(8'hE4, {twdm_pkg::TWDM_UNLOCK_PASSWORD, 8'h01});
        wr(8'h4C, 32'h0000_0022);
        rdc(8'h4C, 32'h0000_0011);
        chk(32'(irq), 32'h0000_0000);
        wr(8'h58, 32'h0000_0001);
        rdc(8'hE8, 32'h0000_4C01);
        chk(32'(irq), 32'h0000_0001);
        // the flag clears on read; the source field keeps the last offending offset
        rdc(8'hE8, 32'h0000_4C00);
        wr(8'hE4, {24'h54_5748, 8'h00});
        wr(8'h5C, 32'h0000_000F);
        rdc(8'hE8, 32'h0000_5C01);
        wr(8'h54, 32'h0000_0001);
        rdc(8'h54, 32'h0000_0000);
        chk(32'(irq), 32'h0000_0000);
        wr(8'hE4, {twdm_pkg::TWDM_UNLOCK_PASSWORD, 8'h00});
        wr(8'h4C, 32'hA533_2211);
        rdc(8'h4C, 32'hA533_2211);
    endtask : t_protect

    // nine pushes into an eight deep queue: the last is dropped and flagged
    task automatic t_tx;
        for (int i = 0; i < 9; i++) wr(8'h34, 32'hFFFF_FF00 | i);
        rdc(8'h50, 32'h0000_0008);
        rdc(8'h54, 32'h0000_0002);
        for (int i = 0; i < 8; i++) begin
            chk(32'(tx_out), 32'h0000_0100 + 32'(i));
            far_u.pop();
        end
        rdc(8'h50, 32'h0000_0000);
    endtask : t_tx

    task automatic t_rx;
        for (int i = 0; i < 3; i++) far_u.rx(8'hA0 + 8'(i));
        rdc(8'h50, 32'h0003_0000);
        for (int i = 0; i < 3; i++) rdc(8'h30, 32'h0000_00A0 + 32'(i));
        rdc(8'h50, 32'h0000_0000);
    endtask : t_rx

    // each extra address alone, then a miss on a disabled one, then the data byte gate
    task automatic t_wake;
        for (int i = 0; i < 3; i++) begin
            wr(8'h5C, 32'(1 << i));
            far_u.wake(7'h11 * 7'(i + 1), 1'b0, 8'h00);
            far_u.wake(7'h11 * 7'(((i + 1) % 3) + 1), 1'b0, 8'h00);
            chk(32'(n_wake), 32'(i + 1));
        end
        wr(8'h5C, 32'h0000_0009);
        far_u.wake(7'h11, 1'b1, 8'h5A);
        far_u.wake(7'h11, 1'b1, 8'hA5);
        chk(32'(n_wake), 32'h0000_0004);
    endtask : t_wake

    task automatic print_verdict;
        $display("comparisons %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict

    // reset for 16 cycles, first access after the second edge that sees reset high
    initial begin
        bus = '0;
        reset_n = 1'b0;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        t_regs();
        t_protect();
        t_tx();
        t_rx();
        t_wake();
        print_verdict();
    end
endmodule : twdm_regs_tb_top
